//--- hw/cmd_frame_pkg.sv
// Package: frame layout, status codes and carrier structs of the command frame handler
package cmd_frame_pkg;
    localparam int FRAME_BYTES = 9;
    localparam int CORE_BYTES = 7;
    localparam int CAN_REPLY_BYTES = 7;
    localparam int CNT_W = 4;
    localparam logic [3:0] IDX_ADDR = 4'h0;
    localparam logic [3:0] IDX_CMD = 4'h1;
    localparam logic [3:0] IDX_TYPE = 4'h2;
    localparam logic [3:0] IDX_BANK = 4'h3;
    localparam logic [3:0] IDX_VAL0 = 4'h4;
    localparam logic [3:0] IDX_VAL3 = 4'h7;
    localparam logic [3:0] IDX_SUM = 4'h8;
    localparam logic [7:0] ST_OK = 8'h64;
    localparam logic [7:0] ST_STORED = 8'h65;
    localparam logic [7:0] ST_BAD_SUM = 8'h01;
    localparam logic [7:0] ST_BAD_CMD = 8'h02;
    localparam logic [7:0] ST_BAD_TYPE = 8'h03;
    localparam logic [7:0] ST_BAD_VALUE = 8'h04;
    localparam logic [7:0] ST_LOCKED = 8'h05;
    localparam logic [7:0] ST_NOT_AVAIL = 8'h06;
    localparam logic [31:0] ZERO_VALUE = 32'h0000_0000;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam int FIFO_DEPTH = 16;

    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] kind;
        logic [7:0] bank;
        logic [31:0] value;
    } command_type;

    typedef struct packed {
        logic [7:0] status;
        logic [31:0] value;
    } result_type;
endpackage : cmd_frame_pkg

//--- hw/binary_command_frame_handler.sv
// Command frame receiver, executor handshake and reply framer with a reply byte FIFO
//
// Overview of operation
// - Transmit only as reply to received command.
// - Drive link only while a reply leaves.
// - Core command is seven bytes.
// - Serial frame: address, core, checksum: nine bytes.
// - Command checksum: 8-bit sum of eight bytes.
// - CAN frame: no address, no checksum.
// - One reply per completed command.
// - Serial reply: nine bytes, value MSB first.
// - Reply checksum: 8-bit sum of others.
// - CAN reply: no reply address, no checksum.
// - Status 100 executed, 101 stored.
// - Error statuses 1 through 6.
`timescale 1ns/10ps

// ------------------------------------------------------------
// Reply byte FIFO
// ------------------------------------------------------------
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Filling side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // Draining side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] rdPtr;
        logic [AW-1:0] wrPtr;
        logic [AW:0] count;
    } fifo_state_type;
    logic [WIDTH-1:0] mem [DEPTH];
    fifo_state_type state_reg;
    fifo_state_type state_next;
    logic push;
    logic pop;

    assign push = inValid && inReady;
    assign pop = outValid && outReady;
    assign inReady = state_reg.count != (AW + 1)'(DEPTH);
    assign outValid = state_reg.count != '0;
    assign outData = mem[state_reg.rdPtr];

    // ------------------------------------------------------------
    // Pointers and fill count
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        if (push) begin
            state_next.wrPtr = state_reg.wrPtr + 1'b1;
        end
        if (pop) begin
            state_next.rdPtr = state_reg.rdPtr + 1'b1;
        end
        state_next.count = state_reg.count + (AW + 1)'(push) - (AW + 1)'(pop);
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
        if (push) begin
            mem[state_reg.wrPtr] <= inData;
        end
    end
endmodule : byte_fifo

// ------------------------------------------------------------
// Frame handler
// ------------------------------------------------------------
// Bytes arriving while a command is busy are dropped; the host must wait
module binary_command_frame_handler #(
    parameter int FIFO_DEPTH = cmd_frame_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Configuration
    input wire logic canMode,
    input wire logic [7:0] moduleAddress,
    input wire logic [7:0] replyAddress,
    // Received bytes, same clock domain
    input wire logic rxValid,
    input wire logic [7:0] rxByte,
    input wire logic rxFrameStart,
    // Command executor
    output logic cmdValid,
    output cmd_frame_pkg::command_type cmdOut,
    input wire logic resultValid,
    input wire cmd_frame_pkg::result_type resultIn,
    input wire logic resultHasValue,
    // Transmit side
    output logic txValid,
    input wire logic txReady,
    output logic [7:0] txByte,
    output logic txDriveEnable,
    output logic txLastByte
);
    typedef enum logic [1:0] {RECEIVE, EXECUTE, REPLY, DRAIN} phase_type;
    typedef struct packed {
        phase_type phase;
        logic [cmd_frame_pkg::CNT_W-1:0] rxCount;
        logic [7:0] rxSum;
        logic [7:0] rxAddr;
        cmd_frame_pkg::command_type cmd;
        logic badSum;
        logic cmdValid;
        logic [7:0] replyStatus;
        logic [31:0] replyValue;
        logic [cmd_frame_pkg::CNT_W-1:0] txCount;
        logic [7:0] txSum;
        logic txValid;
        logic [7:0] txByte;
        logic txDrive;
        logic txLast;
    } handler_state_type;

    handler_state_type state_reg;
    handler_state_type state_next;
    logic fifoInValid;
    logic fifoInReady;
    logic [8:0] fifoInData;
    logic fifoOutValid;
    logic fifoOutReady;
    logic [8:0] fifoOutData;
    logic [cmd_frame_pkg::CNT_W-1:0] replyLen;
    logic [cmd_frame_pkg::CNT_W-1:0] replyIdx;

    function automatic logic [7:0] value_byte(input logic [31:0] v, input logic [1:0] i);
        logic [7:0] b;
        b = v[8 * (3 - i) +: 8];
        return b;
    endfunction : value_byte

    function automatic logic [cmd_frame_pkg::CNT_W-1:0] frame_len(input logic can);
        logic [cmd_frame_pkg::CNT_W-1:0] n;
        n = can ? cmd_frame_pkg::CNT_W'(cmd_frame_pkg::CORE_BYTES)
                : cmd_frame_pkg::CNT_W'(cmd_frame_pkg::FRAME_BYTES);
        return n;
    endfunction : frame_len

    assign replyLen = canMode ? cmd_frame_pkg::CNT_W'(cmd_frame_pkg::CAN_REPLY_BYTES)
                              : cmd_frame_pkg::CNT_W'(cmd_frame_pkg::FRAME_BYTES);
    // CAN replies drop the reply address, so they start at the module address
    assign replyIdx = canMode ? state_reg.txCount + 4'h1 : state_reg.txCount;

    byte_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) replyFifo (
        .ref_clk(ref_clk),
        .reset(reset),
        .inValid(fifoInValid),
        .inReady(fifoInReady),
        .inData(fifoInData),
        .outValid(fifoOutValid),
        .outReady(fifoOutReady),
        .outData(fifoOutData)
    );

    // ------------------------------------------------------------
    // Reply byte generation
    // ------------------------------------------------------------
    always_comb begin
        logic [7:0] b;
        b = cmd_frame_pkg::ZERO_BYTE;
        unique case (replyIdx)
            cmd_frame_pkg::IDX_ADDR: b = replyAddress;
            cmd_frame_pkg::IDX_CMD: b = moduleAddress;
            cmd_frame_pkg::IDX_TYPE: b = state_reg.replyStatus;
            cmd_frame_pkg::IDX_BANK: b = state_reg.cmd.opcode;
            cmd_frame_pkg::IDX_SUM: b = state_reg.txSum;
            default: b = value_byte(state_reg.replyValue, 2'(replyIdx - cmd_frame_pkg::IDX_VAL0));
        endcase
        fifoInValid = state_reg.phase == REPLY;
        fifoInData = {state_reg.txCount == replyLen - 4'h1, b};
    end

    // A stalled link keeps the last byte up, so the FIFO only drains on a free output
    assign fifoOutReady = !state_reg.txValid || txReady;

    // ------------------------------------------------------------
    // Frame receive, execute and reply sequencing
    // ------------------------------------------------------------
    always_comb begin
        logic [3:0] idx;
        logic [3:0] last;
        state_next = state_reg;
        state_next.cmdValid = 1'b0;
        idx = canMode ? state_reg.rxCount + 4'h1 : state_reg.rxCount;
        last = frame_len(canMode) - 4'h1;
        if (rxFrameStart) begin
            state_next.rxCount = '0;
            state_next.rxSum = cmd_frame_pkg::ZERO_BYTE;
        end
        unique case (state_reg.phase)
            RECEIVE: begin
                if (rxValid) begin
                    state_next.rxCount = (rxFrameStart ? 4'h0 : state_reg.rxCount) + 4'h1;
                    state_next.rxSum = (rxFrameStart ? 8'h00 : state_reg.rxSum) + rxByte;
                    if (rxFrameStart) begin
                        idx = canMode ? 4'h1 : 4'h0;
                    end
                    unique case (idx)
                        cmd_frame_pkg::IDX_ADDR: state_next.rxAddr = rxByte;
                        cmd_frame_pkg::IDX_CMD: state_next.cmd.opcode = rxByte;
                        cmd_frame_pkg::IDX_TYPE: state_next.cmd.kind = rxByte;
                        cmd_frame_pkg::IDX_BANK: state_next.cmd.bank = rxByte;
                        cmd_frame_pkg::IDX_SUM: state_next.badSum = rxByte != state_reg.rxSum;
                        default: state_next.cmd.value = {state_reg.cmd.value[23:0], rxByte};
                    endcase
                    if (idx == cmd_frame_pkg::IDX_SUM || (canMode && idx == cmd_frame_pkg::IDX_VAL3)) begin
                        state_next.rxCount = '0;
                        state_next.rxSum = cmd_frame_pkg::ZERO_BYTE;
                        if (!canMode && state_reg.rxAddr != moduleAddress) begin
                            state_next.phase = RECEIVE;
                        end else if (!canMode && rxByte != state_reg.rxSum) begin
                            state_next.replyStatus = cmd_frame_pkg::ST_BAD_SUM;
                            state_next.replyValue = cmd_frame_pkg::ZERO_VALUE;
                            state_next.txSum = replyAddress + moduleAddress
                                + cmd_frame_pkg::ST_BAD_SUM + state_next.cmd.opcode;
                            state_next.txCount = '0;
                            state_next.phase = REPLY;
                        end else begin
                            state_next.cmdValid = 1'b1;
                            state_next.phase = EXECUTE;
                        end
                    end
                end
                if (last == 4'h0) begin
                    state_next.phase = RECEIVE;
                end
            end
            EXECUTE: begin
                if (resultValid) begin
                    state_next.replyStatus = resultIn.status;
                    state_next.replyValue = (resultHasValue && resultIn.status == cmd_frame_pkg::ST_OK)
                        ? resultIn.value : cmd_frame_pkg::ZERO_VALUE;
                    state_next.txSum = replyAddress + moduleAddress + resultIn.status
                        + state_reg.cmd.opcode
                        + state_next.replyValue[31:24] + state_next.replyValue[23:16]
                        + state_next.replyValue[15:8] + state_next.replyValue[7:0];
                    state_next.txCount = '0;
                    state_next.phase = REPLY;
                end
            end
            REPLY: begin
                if (fifoInReady) begin
                    state_next.txCount = state_reg.txCount + 4'h1;
                    if (state_reg.txCount == replyLen - 4'h1) begin
                        state_next.phase = DRAIN;
                    end
                end
            end
            DRAIN: begin
                // Leave as the last byte is taken, so the drive drops with it
                if (!fifoOutValid && (!state_reg.txValid || txReady)) begin
                    state_next.phase = RECEIVE;
                end
            end
        endcase
        if (fifoOutReady) begin
            state_next.txValid = fifoOutValid;
            state_next.txByte = fifoOutValid ? fifoOutData[7:0] : cmd_frame_pkg::ZERO_BYTE;
            state_next.txLast = fifoOutValid && fifoOutData[8];
        end
        // Drive enable spans the reply only, released once the last byte is taken
        state_next.txDrive = state_next.phase == REPLY || state_next.phase == DRAIN
            || state_next.txValid;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_reg <= '0;
            state_reg.phase <= RECEIVE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign cmdValid = state_reg.cmdValid;
    assign cmdOut = state_reg.cmd;
    assign txValid = state_reg.txValid;
    assign txByte = state_reg.txByte;
    assign txDriveEnable = state_reg.txDrive;
    assign txLastByte = state_reg.txLast;
endmodule : binary_command_frame_handler

//--- sim/reply_checker_props.sv
// Port-level assertions for the command frame handler
`timescale 1ns/10ps
module reply_checker (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Configuration and inputs
    input wire logic canMode,
    input wire logic [7:0] moduleAddress,
    input wire logic [7:0] replyAddress,
    input wire logic rxValid,
    input wire logic resultValid,
    input wire logic txReady,
    // Outputs
    input wire logic cmdValid,
    input wire logic txValid,
    input wire logic [7:0] txByte,
    input wire logic txDriveEnable,
    input wire logic txLastByte
);
    logic armed_reg;
    logic [3:0] cnt_reg;
    logic [7:0] sum_reg;
    wire take = txValid && txReady;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    // ------------------------------
    // Reply tracking
    // ------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            armed_reg <= 1'b0;
            cnt_reg <= 4'h0;
            sum_reg <= 8'h00;
        end else begin
            if (take && txLastByte) begin
                armed_reg <= 1'b0;
            end else if (rxValid) begin
                armed_reg <= 1'b1;
            end
            if (take) begin
                cnt_reg <= txLastByte ? 4'h0 : cnt_reg + 4'h1;
                sum_reg <= txLastByte ? 8'h00 : sum_reg + txByte;
            end
        end
    end
    AST_NO_UNSOLICITED: assert property (txValid |-> armed_reg)
        else $error("reply byte without a command");
    AST_DRIVE_COVERS: assert property (txValid |-> txDriveEnable)
        else $error("reply byte while not driving");
    AST_RELEASE: assert property (take && txLastByte |=> !txDriveEnable)
        else $error("link held after reply");
    AST_CMD_PULSE: assert property (cmdValid |=> !cmdValid)
        else $error("command strobe longer than a cycle");
    AST_ANSWER: assert property (resultValid |-> ##[1:8] txValid)
        else $error("no reply after result");
    AST_HOLD: assert property (txValid && !txReady |=> txValid && $stable(txByte))
        else $error("reply byte changed before taken");
    AST_LENGTH: assert property (take && txLastByte |-> cnt_reg == (canMode ? 4'h6 : 4'h8))
        else $error("reply length wrong");
    AST_REPLY_ADDR: assert property (txValid && cnt_reg == 4'h0 && !canMode
        |-> txByte == replyAddress)
        else $error("first reply byte wrong");
    AST_MOD_ADDR: assert property (txValid && cnt_reg == (canMode ? 4'h0 : 4'h1)
        |-> txByte == moduleAddress)
        else $error("module address byte wrong");
    AST_SUM: assert property (txValid && txLastByte && !canMode |-> txByte == sum_reg)
        else $error("reply checksum wrong");
    cover property (take && txLastByte && canMode);
    cover property (take && txLastByte && !canMode);
    cover property (txValid && !txReady);
endmodule : reply_checker
bind binary_command_frame_handler reply_checker reply_checker_i (.ref_clk, .reset, .canMode,
    .moduleAddress, .replyAddress, .rxValid, .resultValid, .txReady, .cmdValid, .txValid,
    .txByte, .txDriveEnable, .txLastByte);

//--- sim/exec_model.sv
// Executor stand-in answering each accepted command after a set delay
`timescale 1ns/10ps
module exec_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Command side
    input wire logic cmdValid,
    input wire cmd_frame_pkg::command_type cmdOut,
    // Answer setup
    input wire logic [7:0] statusCode,
    input wire logic [3:0] delay,
    // Result side
    output logic resultValid,
    output cmd_frame_pkg::result_type resultIn
);
    logic [3:0] cnt_reg;
    // Inverted value so an echo of the command cannot pass
    assign resultIn = {statusCode, ~cmdOut.value};
    always @(posedge ref_clk) begin
        resultValid <= 1'b0;
        if (reset || cmdValid) begin
            cnt_reg <= reset ? 4'h0 : delay;
        end else if (cnt_reg == 4'h1) begin
            resultValid <= 1'b1;
            cnt_reg <= 4'h0;
        end else if (cnt_reg != 4'h0) begin
            cnt_reg <= cnt_reg - 4'h1;
        end
    end
endmodule : exec_model

//--- sim/tb_top.sv
// Self-checking bench of the command frame handler
`timescale 1ns/10ps
module tb_top;
    logic ref_clk = 1'b0, reset = 1'b1, canMode = 1'b0, rxValid = 1'b0, rxFrameStart = 1'b0;
    logic resultHasValue = 1'b0, txReady = 1'b0, cmdValid, resultValid, txValid;
    logic txDriveEnable, txLastByte;
    logic [7:0] moduleAddress = 8'h2C, replyAddress = 8'h02, rxByte = 8'h00;
    logic [7:0] statusCode = 8'h64, txByte;
    logic [3:0] delay = 4'h1;
    cmd_frame_pkg::command_type cmdOut;
    cmd_frame_pkg::result_type resultIn;
    int n_errors = 0, total_checks = 0, nCmd = 0;
    int seed = 32'hBFF36E8E, stallSeed = 32'h00001234;
    logic [7:0] got[$];
    logic [7:0] stTab[7] = '{8'h64, 8'h65, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06};
    binary_command_frame_handler binary_command_frame_handler_i (.ref_clk, .reset, .canMode,
        .moduleAddress, .replyAddress, .rxValid, .rxByte, .rxFrameStart, .cmdValid, .cmdOut,
        .resultValid, .resultIn, .resultHasValue, .txValid, .txReady, .txByte,
        .txDriveEnable, .txLastByte);
    exec_model exec_model_i (.ref_clk, .reset, .cmdValid, .cmdOut, .statusCode, .delay,
        .resultValid, .resultIn);
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        if (txValid && txReady) got.push_back(txByte);
        if (cmdValid) nCmd++;
        txReady <= #1 ($random(stallSeed) % 4) != 0;
    end
    function automatic logic [7:0] sum8(input logic [7:0] q[$]);
        sum8 = 8'h00;
        foreach (q[k]) sum8 += q[k];
    endfunction : sum8
    task check(input string what, input logic [55:0] seen, input logic [55:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    task send(input logic [7:0] b[$]);
        foreach (b[k]) begin
            @(posedge ref_clk) #1;
            rxValid = 1'b1;
            rxByte = b[k];
            rxFrameStart = (k == 0);
        end
        @(posedge ref_clk) #1;
        rxValid = 1'b0;
        rxFrameStart = 1'b0;
    endtask : send
    task run(input logic [7:0] adr, input cmd_frame_pkg::command_type c,
             input logic [7:0] st, input logic bad);
        logic [7:0] f[$];
        logic [7:0] e[$];
        logic [7:0] es;
        logic [31:0] ev;
        int n0;
        f = {c.opcode, c.kind, c.bank, c.value[31:24], c.value[23:16], c.value[15:8],
             c.value[7:0]};
        if (!canMode) begin
            f.push_front(adr);
            f.push_back(sum8(f) + 8'(bad));
        end
        es = bad ? cmd_frame_pkg::ST_BAD_SUM : st;
        ev = (es === cmd_frame_pkg::ST_OK && resultHasValue) ? ~c.value
            : cmd_frame_pkg::ZERO_VALUE;
        e = {es, c.opcode, ev[31:24], ev[23:16], ev[15:8], ev[7:0]};
        // CAN replies keep the module address byte
        e.push_front(moduleAddress);
        if (!canMode) begin
            e.push_front(replyAddress);
            e.push_back(sum8(e));
            if (adr !== moduleAddress) e.delete();
        end
        statusCode = st;
        got.delete();
        n0 = nCmd;
        send(f);
        // Next command only once the whole reply is in
        for (int w = 0; w < 200; w++) begin
            @(posedge ref_clk) #1;
            if (e.size() != 0 && got.size() == e.size() && !txDriveEnable) break;
        end
        check("reply length", got.size(), e.size());
        foreach (e[k]) check("reply byte", got[k], e[k]);
        check("command count", nCmd - n0, (bad || e.size() == 0) ? 0 : 1);
        if (nCmd != n0) check("command", cmdOut, c);
    endtask : run
    task test_done;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : test_done
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        test_done;
    end
    initial begin
        cmd_frame_pkg::command_type c;
        repeat (20) @(posedge ref_clk);
        #1 reset = 1'b0;
        for (int i = 0; i < 18; i++) begin
            c = 56'({$random(seed), $random(seed)});
            if (i == 3) c.value = 32'hFFFF_FFFF;
            canMode = i >= 14;
            resultHasValue = 1'($random(seed));
            delay = 4'h1 + 4'($unsigned($random(seed)) % 8);
            run(i == 12 ? 8'h2D : moduleAddress, c, stTab[i % 7], i == 11);
            $display("test %0d done", i);
        end
        test_done;
    end
endmodule : tb_top
